// ### rtl/pcpm_top.sv
// pulse channel position monitor: top level with register port
// assumes one system clock, a same-clock pulse generator and sequencer,
// and a strap pin that reports the second output adapter
//
// Overview of operation
// - forward pulse adds one, reverse subtracts one
// - position is signed 32-bit two's complement
// - overflow past maximum wraps to minimum
// - underflow past minimum wraps to maximum
// - position is not kept across power loss
// - shared complete flag on successful pulse end
// - shared abnormal flag on unsuccessful end
// - variable-speed output never sets complete flag
// - flags renewed per instruction, sampled right after
// - busy flag high while channel emits pulses
// - active flag high while instruction is activated
// - active stays high after completion until deactivation
// - active low when nothing is activated
// - fourth channel only with two output adapters
`timescale 1ns/1ps
module pcpm_top
   import pcpm_pkg::*;
#(
   parameter int P_NUM_CH = PCPM_MAX_CH,
   parameter int P_POS_W = PCPM_POS_W
)
(
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic [PCPM_ADDR_W-1:0] i_addr,
   input wire logic [PCPM_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [PCPM_DATA_W-1:0] o_rdata,
   input wire pcpm_chan_in_s [PCPM_MAX_CH-1:0] i_chan,
   input wire pcpm_end_s i_end,
   input wire logic i_two_adapters,
   output logic o_instr_complete_flag,
   output logic o_instr_abnormal_end_flag,
   output logic [PCPM_MAX_CH-1:0] o_busy_flag,
   output logic [PCPM_MAX_CH-1:0] o_instr_active_flag,
   output logic [PCPM_MAX_CH-1:0] o_chan_present
);

   // elaboration checks
   generate
      if (P_NUM_CH < 1 || P_NUM_CH > PCPM_MAX_CH) begin : g_bad_nch
         $error("pcpm_top: channel count must be 1 to 4");
      end
      if (P_POS_W != PCPM_DATA_W) begin : g_bad_w
         $error("pcpm_top: position width must equal data width");
      end
      if (int'(PCPM_OFS_POS0) + PCPM_MAX_CH * int'(PCPM_POS_STRIDE)
          > int'(PCPM_OFS_STAT)) begin : g_bad_map
         $error("pcpm_top: position registers overlap the status word");
      end
      if (PCPM_OFS_STAT == PCPM_OFS_CFG) begin : g_bad_ofs
         $error("pcpm_top: status and config share an offset");
      end
      if (PCPM_STAT_ABN_BIT >= PCPM_STAT_BUSY_LSB ||
          PCPM_STAT_BUSY_LSB + PCPM_MAX_CH > PCPM_STAT_ACT_LSB ||
          PCPM_STAT_ACT_LSB + PCPM_MAX_CH > PCPM_STAT_LAST_LSB ||
          PCPM_STAT_LAST_LSB + 2 > PCPM_DATA_W) begin : g_bad_stat
         $error("pcpm_top: status fields overlap or overflow");
      end
      if (PCPM_CFG_PRES_LSB + PCPM_MAX_CH > PCPM_CFG_NCH_LSB ||
          PCPM_CFG_NCH_LSB + 3 > PCPM_DATA_W) begin : g_bad_cfg
         $error("pcpm_top: config fields overlap or overflow");
      end
      if (PCPM_MAX_CH > 4 || PCPM_STRAP_SETTLE + 1 > 7) begin : g_bad_cnt
         $error("pcpm_top: channel select or settle count too wide");
      end
   endgenerate

   localparam int LAST_CH = PCPM_MAX_CH - 1;
   // the sync output needs one cycle beyond its flops before it agrees
   localparam logic [2:0] SETTLE_CNT = 3'(PCPM_STRAP_SETTLE + 1);

   logic strap_level;
   logic strap_taken;
   logic fourth_ok;
   logic [2:0] settle;
   logic [PCPM_MAX_CH-1:0] present;
   logic [PCPM_MAX_CH-1:0] pos_wr;
   logic [P_POS_W-1:0] pos [PCPM_MAX_CH];
   pcpm_chan_st_s [PCPM_MAX_CH-1:0] chan_st;
   logic cmpl;
   logic abn;
   logic [1:0] last_chan;
   logic end_valid;
   logic [PCPM_DATA_W-1:0] next_rdata;
   logic [PCPM_DATA_W-1:0] stat_word;
   logic [PCPM_DATA_W-1:0] cfg_word;

   // strap for the fourth channel, caught after reset release
   pcpm_sync3 u_strap (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_async(i_two_adapters),
      .o_level(strap_level)
   );

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         settle <= 3'h0;
         strap_taken <= 1'b0;
         fourth_ok <= 1'b0;
      end else if (i_ce && !strap_taken) begin
         if (settle == SETTLE_CNT) begin
            strap_taken <= 1'b1;
            fourth_ok <= strap_level;
         end else begin
            settle <= settle + 3'h1;
         end
      end
   end

   // channel presence
   always_comb begin
      for (int i = 0; i < PCPM_MAX_CH; i++) begin
         present[i] = (i < P_NUM_CH);
      end
      present[LAST_CH] = (P_NUM_CH > LAST_CH) & fourth_ok;
   end

   // position write strobes
   always_comb begin
      for (int i = 0; i < PCPM_MAX_CH; i++) begin
         pos_wr[i] = i_wr & pcpm_hit(i_addr, pcpm_pos_addr(i));
      end
   end

   // channels
   genvar gi;
   generate
      for (gi = 0; gi < PCPM_MAX_CH; gi++) begin : g_ch
         pcpm_chan #(
            .P_POS_W(P_POS_W)
         ) u_chan (
            .i_clk_sys(i_clk_sys),
            .i_resetn(i_resetn),
            .i_ce(i_ce),
            .i_present(present[gi]),
            .i_chan(i_chan[gi]),
            .i_wr(pos_wr[gi]),
            .i_wdata(i_wdata),
            .o_pos(pos[gi]),
            .o_st(chan_st[gi])
         );
      end
   endgenerate

   // end reports count only for a present channel
   always_comb begin
      end_valid = present[i_end.chan];
   end

   // shared end flags: a new instruction clears both, its end sets at most one;
   // an end in the same cycle as a start wins over the clear
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         cmpl <= 1'b0;
         abn <= 1'b0;
      end else if (i_ce) begin
         if (end_valid && i_end.abn) begin
            abn <= 1'b1;
            cmpl <= 1'b0;
         end else if (end_valid && i_end.ok) begin
            cmpl <= !i_end.vspeed;
            abn <= 1'b0;
         end else if (end_valid && i_end.start) begin
            cmpl <= 1'b0;
            abn <= 1'b0;
         end
      end
   end

   // channel of the latest reported end
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         last_chan <= 2'h0;
      end else if (i_ce && end_valid && (i_end.ok || i_end.abn)) begin
         last_chan <= i_end.chan;
      end
   end

   // status and configuration words
   always_comb begin
      stat_word = PCPM_RD_ZERO;
      stat_word[PCPM_STAT_CMPL_BIT] = cmpl;
      stat_word[PCPM_STAT_ABN_BIT] = abn;
      stat_word[PCPM_STAT_LAST_LSB +: 2] = last_chan;
      for (int i = 0; i < PCPM_MAX_CH; i++) begin
         stat_word[PCPM_STAT_BUSY_LSB + i] = chan_st[i].busy;
         stat_word[PCPM_STAT_ACT_LSB + i] = chan_st[i].active;
      end
      cfg_word = PCPM_RD_ZERO;
      cfg_word[PCPM_CFG_PRES_LSB +: PCPM_MAX_CH] = present;
      cfg_word[PCPM_CFG_NCH_LSB +: 3] = 3'(P_NUM_CH);
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      next_rdata = PCPM_RD_ZERO;
      for (int i = 0; i < PCPM_MAX_CH; i++) begin
         if (pcpm_hit(i_addr, pcpm_pos_addr(i))) begin
            next_rdata = PCPM_DATA_W'(pos[i]);
         end
      end
      if (pcpm_hit(i_addr, PCPM_OFS_STAT)) begin
         next_rdata = stat_word;
      end
      if (pcpm_hit(i_addr, PCPM_OFS_CFG)) begin
         next_rdata = cfg_word;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= PCPM_RD_ZERO;
      end else if (i_ce) begin
         o_rdata <= i_rd ? next_rdata : PCPM_RD_ZERO;
      end
   end

   // flag outputs
   always_comb begin
      o_instr_complete_flag = cmpl;
      o_instr_abnormal_end_flag = abn;
      o_chan_present = present;
      for (int i = 0; i < PCPM_MAX_CH; i++) begin
         o_busy_flag[i] = chan_st[i].busy;
         o_instr_active_flag[i] = chan_st[i].active;
      end
   end

endmodule

// ### common/pcpm_pkg.sv
// pulse channel position monitor: shared constants, types and functions
// assumes one 20 MHz system clock and a plain word-wide register port
package pcpm_pkg;

   localparam int PCPM_MAX_CH = 4;
   localparam int PCPM_POS_W = 32;
   localparam int PCPM_ADDR_W = 5;
   localparam int PCPM_DATA_W = 32;

   // clock and strap settling
   localparam int PCPM_CLK_HZ = 20000000;
   localparam int PCPM_STRAP_SETTLE = 3;

   // register byte addresses
   localparam logic [4:0] PCPM_OFS_POS0 = 5'h00;
   localparam logic [4:0] PCPM_POS_STRIDE = 5'h04;
   localparam logic [4:0] PCPM_OFS_STAT = 5'h10;
   localparam logic [4:0] PCPM_OFS_CFG = 5'h14;

   // status register fields
   localparam int PCPM_STAT_CMPL_BIT = 0;
   localparam int PCPM_STAT_ABN_BIT = 1;
   localparam int PCPM_STAT_BUSY_LSB = 4;
   localparam int PCPM_STAT_ACT_LSB = 8;
   localparam int PCPM_STAT_LAST_LSB = 12;

   // configuration register fields
   localparam int PCPM_CFG_PRES_LSB = 0;
   localparam int PCPM_CFG_NCH_LSB = 8;

   localparam logic [31:0] PCPM_POS_RST = 32'h0000_0000;
   localparam logic [31:0] PCPM_RD_ZERO = 32'h0000_0000;

   // per-channel inputs from the pulse generator (same clock)
   typedef struct packed {
      logic fwd;
      logic rev;
      logic emitting;
      logic activated;
   } pcpm_chan_in_s;

   // end-of-instruction report from the positioning sequencer
   typedef struct packed {
      logic start;
      logic ok;
      logic abn;
      logic vspeed;
      logic [1:0] chan;
   } pcpm_end_s;

   // per-channel monitor state
   typedef struct packed {
      logic busy;
      logic active;
   } pcpm_chan_st_s;

   function automatic logic [4:0] pcpm_pos_addr(input int idx);
      pcpm_pos_addr = PCPM_OFS_POS0 + 5'(idx) * PCPM_POS_STRIDE;
   endfunction

   function automatic logic pcpm_hit(input logic [4:0] addr,
                                     input logic [4:0] ofs);
      pcpm_hit = (addr == ofs);
   endfunction

endpackage

// ### rtl/pcpm_sync3.sv
// three-flop synchroniser for a level from a pin
// assumes the level changes far slower than the system clock
`timescale 1ns/1ps
module pcpm_sync3
   import pcpm_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_async,
   output logic o_level
);

   logic meta;
   logic stage2;
   logic stage3;

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         meta <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else if (i_ce) begin
         meta <= i_async;
         stage2 <= meta;
         stage3 <= stage2;
      end
   end

   // change accepted once the two settled stages agree
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_level <= 1'b0;
      end else if (i_ce && (stage2 == stage3)) begin
         o_level <= stage3;
      end
   end

endmodule

// ### rtl/pcpm_chan.sv
// one pulse channel: signed position counter, busy and active flags
// assumes pulse strobes and levels come from logic on the same clock
`timescale 1ns/1ps
module pcpm_chan
   import pcpm_pkg::*;
#(
   parameter int P_POS_W = PCPM_POS_W
)
(
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_present,
   input wire pcpm_chan_in_s i_chan,
   input wire logic i_wr,
   input wire logic [P_POS_W-1:0] i_wdata,
   output logic [P_POS_W-1:0] o_pos,
   output pcpm_chan_st_s o_st
);

   logic [P_POS_W-1:0] next_pos;
   logic [P_POS_W-1:0] base;

   // a write and a pulse in one cycle: the pulse is applied to the
   // written value so no pulse is lost
   always_comb begin
      base = i_wr ? i_wdata : o_pos;
      next_pos = base;
      if (i_chan.fwd && !i_chan.rev) begin
         next_pos = base + P_POS_W'(1);
      end else if (i_chan.rev && !i_chan.fwd) begin
         next_pos = base - P_POS_W'(1);
      end
   end

   // plain two's-complement, wraps at both ends
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pos <= P_POS_W'(PCPM_POS_RST);
      end else if (i_ce) begin
         if (!i_present) begin
            o_pos <= P_POS_W'(PCPM_POS_RST);
         end else begin
            o_pos <= next_pos;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_st <= '0;
      end else if (i_ce) begin
         o_st.busy <= i_present & i_chan.emitting;
         o_st.active <= i_present & i_chan.activated;
      end
   end

endmodule

// ### tb/pcpm_top_props.sv
// checker for the pulse channel position monitor top ports
// assumes one clock domain; channel 0 is always present
`timescale 1ns/1ps
module pcpm_top_props
   import pcpm_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire pcpm_chan_in_s [PCPM_MAX_CH-1:0] i_chan,
   input wire pcpm_end_s i_end,
   input wire logic i_two_adapters,
   input wire logic o_instr_complete_flag,
   input wire logic o_instr_abnormal_end_flag,
   input wire logic [PCPM_MAX_CH-1:0] o_busy_flag,
   input wire logic [PCPM_MAX_CH-1:0] o_instr_active_flag,
   input wire logic [PCPM_MAX_CH-1:0] o_chan_present
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   logic live, take0, good0, bad0, vsp0, clr0, idle0;
   assign live = i_ce & i_resetn;
   assign take0 = live & (i_end.chan == 2'h0) & o_chan_present[0];
   assign good0 = take0 & i_end.ok & ~i_end.abn & ~i_end.vspeed;
   assign bad0 = take0 & i_end.abn;
   assign vsp0 = take0 & i_end.ok & ~i_end.abn & i_end.vspeed;
   assign clr0 = take0 & i_end.start & ~i_end.ok & ~i_end.abn;
   assign idle0 = live & ~(i_end.start | i_end.ok | i_end.abn);
   chk_cmpl_set:
      assert property ($past(good0)
         |-> o_instr_complete_flag && !o_instr_abnormal_end_flag)
      else $error("complete flag missing after good end");
   chk_abn_set:
      assert property ($past(bad0)
         |-> o_instr_abnormal_end_flag && !o_instr_complete_flag)
      else $error("abnormal flag missing after bad end");
   chk_vspeed_none:
      assert property (vsp0 |=> !o_instr_complete_flag)
      else $error("complete flag set by variable speed end");
   chk_start_clr:
      assert property (clr0
         |=> !o_instr_complete_flag && !o_instr_abnormal_end_flag)
      else $error("end flags not cleared by start");
   chk_flags_hold:
      assert property ($past(idle0) |-> $stable(o_instr_complete_flag)
         && $stable(o_instr_abnormal_end_flag))
      else $error("end flags changed without report");
   chk_busy_follow:
      assert property ($past(live)
         |-> o_busy_flag[0] == $past(i_chan[0].emitting))
      else $error("busy flag does not follow emission");
   chk_active_hold:
      assert property (live && i_chan[0].activated && !i_chan[0].emitting
         |=> o_instr_active_flag[0])
      else $error("active flag low while activated");
   chk_active_drop:
      assert property ($past(live) && !$past(i_chan[0].activated)
         |-> !o_instr_active_flag[0])
      else $error("active flag high while not activated");
   chk_reset_clear:
      assert property (disable iff (1'b0) !i_resetn
         |-> !o_instr_complete_flag && !o_instr_abnormal_end_flag
         && o_busy_flag == 4'h0 && o_instr_active_flag == 4'h0)
      else $error("flags not clear in reset");
   chk_absent_quiet:
      assert property (!o_chan_present[3]
         |-> !o_busy_flag[3] && !o_instr_active_flag[3])
      else $error("absent fourth channel shows busy or active");
   cover property (good0);
   cover property (bad0);
   cover property (vsp0);
endmodule
bind pcpm_top pcpm_top_props pcpm_top_props_inst (.*);

// ### tb/pcpm_drive_model.sv
// servo drive model: counts pulses of one channel, reports in-position
// assumes same-clock pulse strobes; never reset with the controller
`timescale 1ns/1ps
module pcpm_drive_model
   import pcpm_pkg::*;
(
   input wire logic i_clk_sys,
   input wire pcpm_chan_in_s i_chan,
   output logic [31:0] o_abs_pos,
   output logic o_in_pos
);
   logic [31:0] count = 32'h0;
   logic [1:0] quiet = 2'h0;
   // absolute count survives controller reset
   always @(posedge i_clk_sys) begin
      if (i_chan.fwd && !i_chan.rev)
         count <= count + 32'h1;
      if (i_chan.rev && !i_chan.fwd)
         count <= count - 32'h1;
   end
   // in position after three quiet cycles
   always @(posedge i_clk_sys) begin
      if (i_chan.fwd || i_chan.rev)
         quiet <= 2'h0;
      else if (quiet != 2'h3)
         quiet <= quiet + 2'h1;
   end
   assign o_abs_pos = count;
   assign o_in_pos = (quiet == 2'h3);
endmodule

// ### tb/testbench.sv
// testbench for the pulse channel position monitor
// assumes four channels and a drive model on channel 0
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench
   import pcpm_pkg::*;
;
   logic i_clk_sys = 1'b0;
   logic i_resetn = 1'b1;
   logic i_ce = 1'b1;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_two_adapters = 1'b1;
   logic [4:0] i_addr = 5'h0;
   logic [31:0] i_wdata = 32'h0;
   pcpm_chan_in_s [3:0] i_chan = '0;
   pcpm_end_s i_end = '0;
   logic [31:0] o_rdata, abs_pos;
   logic o_instr_complete_flag, o_instr_abnormal_end_flag, in_pos;
   logic [3:0] o_busy_flag, o_instr_active_flag, o_chan_present;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   pcpm_top #(.P_NUM_CH(4)) pcpm_top_inst (.*);
   pcpm_drive_model pcpm_drive_model_inst (.i_clk_sys(i_clk_sys),
      .i_chan(i_chan[0]), .o_abs_pos(abs_pos), .o_in_pos(in_pos));
   initial begin
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   task automatic finish_test();
      if (num_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e,
                      input string n);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 `CHK(n, e, o_rdata)
   endtask
   task automatic pulses(input int ch, input bit rv, input int n);
      @(posedge i_clk_sys);
      if (rv)
         i_chan[ch].rev <= 1'b1;
      else
         i_chan[ch].fwd <= 1'b1;
      repeat (n) @(posedge i_clk_sys);
      i_chan[ch].fwd <= 1'b0;
      i_chan[ch].rev <= 1'b0;
   endtask
   task automatic rep(input logic [3:0] k, input logic c, input logic a);
      @(posedge i_clk_sys);
      i_end <= {k, 2'h0};
      @(posedge i_clk_sys);
      i_end <= '0;
      #1 `CHK("complete", c, o_instr_complete_flag)
      `CHK("abnormal", a, o_instr_abnormal_end_flag)
   endtask
   task automatic lv(input logic e, input logic a, input logic [3:0] b,
                     input logic [3:0] t);
      @(posedge i_clk_sys);
      i_chan[0].emitting <= e;
      i_chan[0].activated <= a;
      repeat (2) @(posedge i_clk_sys);
      #1 `CHK("busy", b, o_busy_flag)
      `CHK("active", t, o_instr_active_flag)
   endtask
   task automatic t_count();
      for (int i = 0; i < 4; i++)
         rdc(5'(i * 4), 32'h0, "pos init");
      rdc(PCPM_OFS_CFG, 32'h0000_040f, "config");
      pulses(0, 1'b0, 5);
      pulses(0, 1'b1, 2);
      pulses(1, 1'b1, 3);
      for (int i = 0; i < 20 && !in_pos; i++)
         @(posedge i_clk_sys);
      rdc(5'h00, 32'h3, "pos0");
      rdc(5'h04, 32'hffff_fffd, "pos1");
   endtask
   task automatic t_wrap();
      wr(5'h0c, 32'h8000_0000);
      rdc(5'h0c, 32'h8000_0000, "pos3 min");
      wr(5'h08, 32'h7fff_ffff);
      pulses(2, 1'b0, 1);
      rdc(5'h08, 32'h8000_0000, "wrap up");
      pulses(2, 1'b1, 1);
      rdc(5'h08, 32'h7fff_ffff, "wrap down");
   endtask
   task automatic t_freeze();
      @(posedge i_clk_sys);
      i_ce <= 1'b0;
      pulses(1, 1'b0, 3);
      @(posedge i_clk_sys);
      i_ce <= 1'b1;
      rdc(5'h04, 32'hffff_fffd, "pos1 frozen");
   endtask
   task automatic t_flags();
      rep(4'h8, 1'b0, 1'b0);
      rep(4'h4, 1'b1, 1'b0);
      rdc(PCPM_OFS_STAT, 32'h0000_0001, "stat complete");
      rep(4'h8, 1'b0, 1'b0);
      rep(4'h2, 1'b0, 1'b1);
      rdc(PCPM_OFS_STAT, 32'h0000_0002, "stat abnormal");
      rep(4'h8, 1'b0, 1'b0);
      rep(4'h5, 1'b0, 1'b0);
   endtask
   task automatic t_levels();
      lv(1'b1, 1'b1, 4'h1, 4'h1);
      rdc(PCPM_OFS_STAT, 32'h0000_0110, "stat levels");
      lv(1'b0, 1'b1, 4'h0, 4'h1);
      lv(1'b0, 1'b0, 4'h0, 4'h0);
   endtask
   task automatic t_absent();
      @(posedge i_clk_sys);
      i_two_adapters <= 1'b0;
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      repeat (12) @(posedge i_clk_sys);
      i_chan[3].emitting <= 1'b1;
      i_chan[3].activated <= 1'b1;
      wr(5'h0c, 32'h0000_0010);
      pulses(3, 1'b0, 2);
      #1 `CHK("present3", 1'b0, o_chan_present[3])
      `CHK("busy3", 4'h0, o_busy_flag)
      `CHK("active3", 4'h0, o_instr_active_flag)
      rdc(5'h0c, 32'h0, "pos3 absent");
      rdc(5'h18, 32'h0, "unmapped");
      @(posedge i_clk_sys);
      i_end <= {4'h4, 2'h3};
      i_chan[3] <= '0;
      i_two_adapters <= 1'b1;
      @(posedge i_clk_sys);
      i_end <= '0;
      #1 `CHK("end absent", 1'b0, o_instr_complete_flag)
   endtask
   task automatic t_power();
      rep(4'h4, 1'b1, 1'b0);
      @(posedge i_clk_sys);
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      repeat (10) @(posedge i_clk_sys);
      rdc(5'h00, 32'h0, "pos0 lost");
      `CHK("complete rst", 1'b0, o_instr_complete_flag)
      wr(5'h00, abs_pos);
      rdc(5'h00, 32'h3, "realign");
   endtask
   initial begin
      i_resetn <= 1'b0;
      repeat (10) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      repeat (10) @(posedge i_clk_sys);
      t_count();
      t_wrap();
      t_freeze();
      t_flags();
      t_levels();
      t_absent();
      t_power();
      finish_test();
   end
endmodule
